// ---- verilog/adc_status_pkg.sv ----
// Purpose: shared constants for the result/status register block
// Assumes: 24-bit result path, 8-bit status byte, serial command byte
// Notes: nothing here is synthesised on its own
`default_nettype none

package adc_status_pkg;

    // =========================================================
    // register select codes and command byte layout
    localparam logic [2:0] SEL_STATUS = 3'h0;
    localparam logic [2:0] SEL_DATA = 3'h1;
    localparam int CMD_OP_MSB = 7;
    localparam int CMD_OP_LSB = 6;
    localparam int CMD_SEL_MSB = 2;
    localparam int CMD_SEL_LSB = 0;
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_CONT_START = 2'h2;
    localparam logic [1:0] OP_CONT_STOP = 2'h3;
    localparam logic [7:0] CMD_STOP_CONT = 8'h30;

    // =========================================================
    // status byte field positions
    localparam int ST_READY_BIT = 7;
    localparam int ST_SETTLED_BIT = 6;
    localparam int ST_STANDBY_BIT = 5;
    localparam int ST_MISSING_REFERENCE_FLAG_BIT = 4;
    localparam int ST_FACTORY_MSB = 3;

    // =========================================================
    // reset values, and the all-ones result used when the reference is missing
    localparam logic RST_READY_N = 1'b1;
    localparam logic RST_SETTLED = 1'b1;
    localparam logic RST_STANDBY = 1'b0;
    localparam logic [23:0] RST_RESULT = 24'h000000;
    localparam logic [23:0] RESULT_ALL_ONES = 24'hFFFFFF;

    // =========================================================
    // modes and lengths
    localparam logic [2:0] MODE_STANDBY = 3'h3;
    localparam logic [4:0] LEN_BYTE = 5'h08;
    localparam logic [4:0] LEN_WORD16 = 5'h10;
    localparam logic [4:0] LEN_WORD24 = 5'h18;

    // =========================================================
    // timing: ready stays high around an overwrite
    localparam int HOLD_MCLK_PERIODS = 100;
    localparam int CLK_PERIOD_NS = 5;
    localparam int MCLK_PERIOD_NS = 5;
    localparam int HOLD_CYCLES = (HOLD_MCLK_PERIODS * MCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// ---- verilog/serial_xfer_if.sv ----
// Purpose: transfer request/answer bundle between control and shifter
// Assumes: one transfer at a time, up to 24 bits, msb first
// Notes: tx_word is right aligned
`timescale 1ns/1ps
`default_nettype none

interface serial_xfer_if;
    logic start;
    logic [4:0] len;
    logic [23:0] tx_word;
    logic abort;
    logic busy;
    logic done;
    logic byte_done;
    logic [7:0] rx_byte;
    logic [23:0] rx_word;

    modport ctrl (output start, output len, output tx_word, output abort,
                  input busy, input done, input byte_done, input rx_byte, input rx_word);
    modport port (input start, input len, input tx_word, input abort,
                  output busy, output done, output byte_done, output rx_byte, output rx_word);
endinterface

`default_nettype wire

// ---- verilog/bit_sync.sv ----
// Purpose: two-flop synchroniser for one pin
// Assumes: input asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // bit_sync

`default_nettype wire

// ---- verilog/serial_shifter.sv ----
// Purpose: bit-level serial shifter, oversampling the serial clock
// Assumes: serial clock idles high; out changes on fall, in sampled on rise
// Notes: inputs arrive already synchronised
`timescale 1ns/1ps
`default_nettype none

module serial_shifter (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk_s,
    input wire logic cs_n_s,
    input wire logic din_s,
    serial_xfer_if.port xf,
    output logic dout,
    output logic dout_oe_n
);
    logic sclk_d_r;
    logic busy_r, busy_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [23:0] out_r, out_nxt;
    logic [23:0] in_r, in_nxt;
    logic [2:0] bytec_r, bytec_nxt;
    logic first_r, first_nxt;
    logic dout_nxt;
    logic done_r, done_nxt;
    logic bdone_r, bdone_nxt;
    logic rise, fall;

    // =========================================================
    // edge finding, on synchronised copies only
    assign rise = sclk_s & ~sclk_d_r;
    assign fall = ~sclk_s & sclk_d_r;

    always_comb begin
        busy_nxt = busy_r;
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        in_nxt = in_r;
        bytec_nxt = bytec_r;
        first_nxt = first_r;
        dout_nxt = dout;
        done_nxt = 1'b0;
        bdone_nxt = 1'b0;
        if (xf.start) begin
            busy_nxt = 1'b1;
            cnt_nxt = xf.len;
            out_nxt = xf.tx_word << (5'd24 - xf.len);
            dout_nxt = out_nxt[23];
            in_nxt = '0;
            bytec_nxt = 3'h0;
            first_nxt = 1'b1;
        end else if (busy_r && xf.abort) begin
            busy_nxt = 1'b0;
        end else if (busy_r && !cs_n_s) begin
            if (rise) begin
                in_nxt = {in_r[22:0], din_s};
                cnt_nxt = cnt_r - 5'd1;
                bytec_nxt = bytec_r + 3'd1;
                first_nxt = 1'b0;
                bdone_nxt = (bytec_r == 3'd7);
                if (cnt_r == 5'd1) begin
                    busy_nxt = 1'b0;
                    done_nxt = 1'b1;
                end
            end else if (fall && !first_r) begin
                // first fall only opens the frame; msb is already out
                out_nxt = {out_r[22:0], 1'b0};
                dout_nxt = out_r[22];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_d_r <= 1'b1;
            busy_r <= 1'b0;
            cnt_r <= 5'h00;
            out_r <= 24'h000000;
            in_r <= 24'h000000;
            bytec_r <= 3'h0;
            first_r <= 1'b0;
            dout <= 1'b0;
            dout_oe_n <= 1'b1;
            done_r <= 1'b0;
            bdone_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            busy_r <= busy_nxt;
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
            in_r <= in_nxt;
            bytec_r <= bytec_nxt;
            first_r <= first_nxt;
            dout <= dout_nxt;
            dout_oe_n <= cs_n_s;
            done_r <= done_nxt;
            bdone_r <= bdone_nxt;
        end
    end

    assign xf.busy = busy_r;
    assign xf.done = done_r;
    assign xf.byte_done = bdone_r;
    assign xf.rx_byte = in_r[7:0];
    assign xf.rx_word = in_r;
endmodule // serial_shifter

`default_nettype wire

// ---- verilog/adc_result_status_registers.sv ----
// Purpose: conversion result register and status byte behind the serial port
// Assumes: result_strobe, cal_done and mode inputs come from logic on clk
// Notes: pins and the reference detector are synchronised here
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// - status bit 7 equals the ready flag driving the ready pin.
// - settled bit re-evaluated at each result load once quick-settle has been active.
// - during quick-settle step response settled stays high while ready falls.
// - once FIR settled, settled bit falls together with ready.
// - without quick-settle, settled clears on first result read only.
// - events raising ready raise settled too, except a result read.
// - standby bit set by standby pin or mode code 011.
// - standby bit resets to 0 with standby pin high.
// - missing-reference bit follows the reference detector.
// - result loads all ones when reference missing at completion.
// - calibration coefficient update blocked when reference missing.
// - low four status bits are factory marker, no reliable value.
// - result register holds latest value, read-only to host.
// - result is 16 or 24 bits per word-length select.
// - ready driven low on pin and bit at each result load.
// - ready returns high after full word read out and at an unread overwrite.
// - unread result overwrite: ready high 100 clocks, then low.
// - selected result write must be shifted before next command.
// - bits written to the result register are discarded.
// - result register resets to zero.
// - continuous read repeats until command byte 30 hex.
module adc_result_status_registers #(
    parameter logic [3:0] FACTORY_MARKER = 4'h0, // arbitrary value
    parameter int HOLD_CYCLES = adc_status_pkg::HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe_n,
    output logic result_ready_n,
    input wire logic standby_n,
    input wire logic ref_missing,
    input wire logic result_strobe,
    input wire logic [23:0] result_value,
    input wire logic quick_settle_active,
    input wire logic fir_settled,
    input wire logic cal_done,
    output logic cal_coeff_write,
    input wire logic word_length_select,
    input wire logic [2:0] operating_mode_field,
    output logic filter_settled_flag,
    output logic standby_flag,
    output logic missing_reference_flag
);
    typedef enum logic [1:0] {IF_CMD, IF_READ, IF_WRITE, IF_CONT} if_state_t;

    serial_xfer_if xf ();

    logic sclk_s, cs_n_s, din_s, standby_flag_n_s, miss_s;

    if_state_t st_r, st_nxt;
    logic [2:0] sel_r, sel_nxt;
    logic start_r, start_nxt;
    logic [4:0] len_r, len_nxt;
    logic [23:0] tx_r, tx_nxt;
    logic abort_r, abort_nxt;

    logic [23:0] data_r, data_nxt;
    logic [23:0] pend_r, pend_nxt;
    logic ready_n_r, ready_n_nxt;
    logic settled_r, settled_nxt;
    logic standby_r, standby_nxt;
    logic quick_used_r, quick_used_nxt;
    logic hold_r, hold_nxt;
    logic [7:0] hold_cnt_r, hold_cnt_nxt;
    logic cal_wr_r, cal_wr_nxt;

    logic [7:0] status_byte;
    logic [23:0] result_eff;
    logic read_done;
    logic stop_seen;
    logic load;
    logic [4:0] data_len;

    // =========================================================
    // pin synchronisers
    bit_sync #(.RST_VAL(1'b1)) u_sync_sclk (.clk(clk), .rst(rst), .d(sclk), .q(sclk_s));
    bit_sync #(.RST_VAL(1'b1)) u_sync_cs (.clk(clk), .rst(rst), .d(cs_n), .q(cs_n_s));
    bit_sync #(.RST_VAL(1'b0)) u_sync_din (.clk(clk), .rst(rst), .d(din), .q(din_s));
    bit_sync #(.RST_VAL(1'b1)) u_sync_standby_flag (.clk(clk), .rst(rst), .d(standby_n), .q(standby_flag_n_s));
    bit_sync #(.RST_VAL(1'b0)) u_sync_ref (.clk(clk), .rst(rst), .d(ref_missing), .q(miss_s));

    serial_shifter u_shifter (
        .clk(clk),
        .rst(rst),
        .sclk_s(sclk_s),
        .cs_n_s(cs_n_s),
        .din_s(din_s),
        .xf(xf.port),
        .dout(dout),
        .dout_oe_n(dout_oe_n)
    );

    assign xf.start = start_r;
    assign xf.len = len_r;
    assign xf.tx_word = tx_r;
    assign xf.abort = abort_r;

    // =========================================================
    // status byte and result framing
    always_comb begin
        status_byte = 8'h00;
        status_byte[adc_status_pkg::ST_READY_BIT] = ready_n_r;
        status_byte[adc_status_pkg::ST_SETTLED_BIT] = settled_r;
        status_byte[adc_status_pkg::ST_STANDBY_BIT] = standby_r;
        status_byte[adc_status_pkg::ST_MISSING_REFERENCE_FLAG_BIT] = miss_s;
        // marker bits carry no meaning for software
        status_byte[adc_status_pkg::ST_FACTORY_MSB:0] = FACTORY_MARKER;
    end

    assign data_len = word_length_select ? adc_status_pkg::LEN_WORD24
                                         : adc_status_pkg::LEN_WORD16;
    assign result_eff = miss_s ? adc_status_pkg::RESULT_ALL_ONES : result_value;

    // =========================================================
    // command interface
    always_comb begin
        st_nxt = st_r;
        sel_nxt = sel_r;
        len_nxt = len_r;
        tx_nxt = tx_r;
        abort_nxt = 1'b0;
        read_done = 1'b0;
        stop_seen = 1'b0;
        // one cycle gap after done or abort so the new state sets up the next frame
        start_nxt = ~xf.busy & ~start_r & ~xf.done & ~abort_r;
        if (start_nxt) begin
            len_nxt = adc_status_pkg::LEN_BYTE;
            tx_nxt = 24'h000000;
            unique case (st_r)
                IF_CMD: begin
                    tx_nxt = 24'h000000;
                end
                IF_READ, IF_CONT: begin
                    if (sel_r == adc_status_pkg::SEL_STATUS) begin
                        tx_nxt = {16'h0000, status_byte};
                    end else if (sel_r == adc_status_pkg::SEL_DATA) begin
                        len_nxt = data_len;
                        tx_nxt = word_length_select ? data_r : {8'h00, data_r[23:8]};
                    end
                end
                IF_WRITE: begin
                    if (sel_r == adc_status_pkg::SEL_DATA) begin
                        len_nxt = data_len;
                    end
                end
            endcase
        end
        if (st_r == IF_CONT && xf.byte_done && xf.rx_byte == adc_status_pkg::CMD_STOP_CONT) begin
            stop_seen = 1'b1;
            st_nxt = IF_CMD;
            abort_nxt = ~xf.done;
        end else if (xf.done) begin
            unique case (st_r)
                IF_CMD: begin
                    sel_nxt = xf.rx_byte[adc_status_pkg::CMD_SEL_MSB:adc_status_pkg::CMD_SEL_LSB];
                    unique case (xf.rx_byte[adc_status_pkg::CMD_OP_MSB:adc_status_pkg::CMD_OP_LSB])
                        adc_status_pkg::OP_WRITE: st_nxt = IF_WRITE;
                        adc_status_pkg::OP_READ: st_nxt = IF_READ;
                        adc_status_pkg::OP_CONT_START: st_nxt = IF_CONT;
                        adc_status_pkg::OP_CONT_STOP: st_nxt = IF_CMD;
                    endcase
                end
                IF_READ: begin
                    read_done = (sel_r == adc_status_pkg::SEL_DATA);
                    st_nxt = IF_CMD;
                end
                IF_WRITE: begin
                    // shifted-in word is dropped, result stays as it was
                    st_nxt = IF_CMD;
                end
                IF_CONT: begin
                    read_done = (sel_r == adc_status_pkg::SEL_DATA);
                end
            endcase
        end
    end

    // =========================================================
    // result register, ready and settled flags
    always_comb begin
        data_nxt = data_r;
        pend_nxt = pend_r;
        ready_n_nxt = ready_n_r;
        settled_nxt = settled_r;
        hold_nxt = hold_r;
        hold_cnt_nxt = hold_cnt_r;
        load = 1'b0;
        quick_used_nxt = quick_used_r | quick_settle_active;
        if (read_done && !stop_seen) begin
            ready_n_nxt = 1'b1;
            if (!quick_used_r) begin
                settled_nxt = 1'b0;
            end
        end
        if (hold_r) begin
            if (result_strobe) begin
                pend_nxt = result_eff;
            end
            if (hold_cnt_r == 8'h00) begin
                hold_nxt = 1'b0;
                load = 1'b1;
            end else begin
                hold_cnt_nxt = hold_cnt_r - 8'h01;
            end
        end else if (result_strobe) begin
            if (!ready_n_r) begin
                // unread word about to go: warn the host before overwriting
                hold_nxt = 1'b1;
                hold_cnt_nxt = 8'(HOLD_CYCLES - 1);
                pend_nxt = result_eff;
                ready_n_nxt = 1'b1;
                settled_nxt = 1'b1;
            end else begin
                pend_nxt = result_eff;
                load = 1'b1;
            end
        end
        if (load) begin
            data_nxt = pend_nxt;
            ready_n_nxt = 1'b0;
            if (quick_used_nxt) begin
                // high through quick-settle response, low with ready once FIR settled
                settled_nxt = ~fir_settled;
            end
        end
        standby_nxt = ~standby_flag_n_s | (operating_mode_field == adc_status_pkg::MODE_STANDBY);
        cal_wr_nxt = cal_done & ~miss_s;
    end

    // =========================================================
    // registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= IF_CMD;
            sel_r <= adc_status_pkg::SEL_STATUS;
            start_r <= 1'b0;
            len_r <= adc_status_pkg::LEN_BYTE;
            tx_r <= 24'h000000;
            abort_r <= 1'b0;
            data_r <= adc_status_pkg::RST_RESULT;
            pend_r <= adc_status_pkg::RST_RESULT;
            ready_n_r <= adc_status_pkg::RST_READY_N;
            settled_r <= adc_status_pkg::RST_SETTLED;
            standby_r <= adc_status_pkg::RST_STANDBY;
            quick_used_r <= 1'b0;
            hold_r <= 1'b0;
            hold_cnt_r <= 8'h00;
            cal_wr_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            sel_r <= sel_nxt;
            start_r <= start_nxt;
            len_r <= len_nxt;
            tx_r <= tx_nxt;
            abort_r <= abort_nxt;
            data_r <= data_nxt;
            pend_r <= pend_nxt;
            ready_n_r <= ready_n_nxt;
            settled_r <= settled_nxt;
            standby_r <= standby_nxt;
            quick_used_r <= quick_used_nxt;
            hold_r <= hold_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            cal_wr_r <= cal_wr_nxt;
        end
    end

    // =========================================================
    // outputs, all from flops
    assign result_ready_n = ready_n_r;
    assign filter_settled_flag = settled_r;
    assign standby_flag = standby_r;
    assign missing_reference_flag = miss_s;
    assign cal_coeff_write = cal_wr_r;
endmodule // adc_result_status_registers

`default_nettype wire

// ---- test/result_status_sva.sv ----
// Purpose: port-level timing checks for the result/status block
// Assumes: one clock domain, async active-high reset
// Notes: bound from the bench; sees top-level ports only
`timescale 1ns/1ps
`default_nettype none
module result_status_sva #(
    parameter int HOLD_CYCLES = 100
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic result_ready_n,
    input wire logic result_strobe,
    input wire logic quick_settle_active,
    input wire logic fir_settled,
    input wire logic filter_settled_flag,
    input wire logic standby_n,
    input wire logic [2:0] operating_mode_field,
    input wire logic standby_flag,
    input wire logic ref_missing,
    input wire logic missing_reference_flag,
    input wire logic cal_done,
    input wire logic cal_coeff_write
);
    // ==========================================
    // overwrite window tracking
    logic pend_r, pend_nxt, sb;
    int hc_r, hc_nxt;
    assign sb = !standby_n || operating_mode_field == adc_status_pkg::MODE_STANDBY;
    always_comb begin
        pend_nxt = (result_strobe && !result_ready_n) ? 1'b1 : (!result_ready_n ? 1'b0 : pend_r);
        hc_nxt = (pend_r && result_ready_n) ? hc_r + 1 : (pend_r ? hc_r : 0);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_r <= 1'b0;
            hc_r <= 0;
        end else begin
            pend_r <= pend_nxt;
            hc_r <= hc_nxt;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // assertions
    a_ready_on_load: assert property (result_strobe && result_ready_n && !pend_r |=> !result_ready_n)
        else $error("ready not low after result load");
    a_overwrite_rise: assert property (result_strobe && !result_ready_n |=> result_ready_n && filter_settled_flag)
        else $error("overwrite did not raise ready and settled");
    a_hold_length: assert property (pend_r && !result_ready_n |-> hc_r >= HOLD_CYCLES)
        else $error("overwrite window too short");
    a_hold_ends: assert property (result_strobe && !result_ready_n |=> result_ready_n ##[1:1000] !result_ready_n)
        else $error("overwrite window never closed");
    a_settled_load: assert property (result_strobe && result_ready_n && !pend_r && quick_settle_active
        |=> filter_settled_flag == !$past(fir_settled))
        else $error("settled flag wrong after quick-settle load");
    a_standby_on: assert property (sb [*4] |-> standby_flag)
        else $error("standby flag not set");
    a_standby_off: assert property (!sb [*4] |-> !standby_flag)
        else $error("standby flag not clear");
    a_missing_reference_flag_on: assert property (ref_missing [*3] |-> missing_reference_flag)
        else $error("missing reference flag not set");
    a_cal_gate: assert property (cal_done |=> cal_coeff_write == !$past(missing_reference_flag))
        else $error("coefficient write not gated by reference");
    c_overwrite: cover property (result_strobe && !result_ready_n);
    c_qs_load: cover property (result_strobe && result_ready_n && quick_settle_active);
    c_cal_blocked: cover property (cal_done && missing_reference_flag);
endmodule // result_status_sva
`default_nettype wire

// ---- test/host_model.sv ----
// Purpose: serial host driving the command/data link
// Assumes: serial clock idles high, 48 ns period
// Notes: dout sampled late in the high phase, well after the shift
`timescale 1ns/1ps
`default_nettype none
module host_model (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe_n
);
    // ==========================================
    // frame engine
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // clock stands still between frames; no stray edges while deselected
    task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
        rx = 24'h000000;
        cs_n = 1'b0;
        #60;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b0;
            din = tx[i];
            #24;
            sclk = 1'b1;
            #24;
            rx = {rx[22:0], dout};
        end
        #60;
        cs_n = 1'b1;
        din = ~din; // line left undriven in spirit: never hold the last bit
        #80;
    endtask
endmodule // host_model
`default_nettype wire

// ---- test/adc_result_status_registers_bench.sv ----
// Purpose: self-checking bench for the result/status block
// Assumes: overwrite window shortened to keep the run brief
// Notes: every serial access goes through the host model
`timescale 1ns/1ps
`default_nettype none
module adc_result_status_registers_bench;
    // ==========================================
    // signals
    localparam int HOLD = 4;
    logic clk, rst, sclk, cs_n, din, dout, dout_oe_n, result_ready_n;
    logic standby_n, ref_missing, result_strobe, quick_settle_active, fir_settled;
    logic cal_done, cal_coeff_write, word_length_select;
    logic filter_settled_flag, standby_flag, missing_reference_flag;
    logic [23:0] result_value, rx;
    logic [2:0] operating_mode_field;
    int n_fail, checked;
    adc_result_status_registers #(.FACTORY_MARKER(4'h5), .HOLD_CYCLES(HOLD)) u_dut (.*);
    host_model u_host (.*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==========================================
    // helpers
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] cmd, input int n);
        logic [23:0] junk;
        u_host.xfer({16'h0000, cmd}, 8, junk);
        u_host.xfer(24'h000000, n, rx);
        @(negedge clk);
    endtask
    task automatic strobe(input logic [23:0] v);
        @(negedge clk);
        result_value = v;
        result_strobe = 1'b1;
        @(negedge clk);
        result_strobe = 1'b0;
        @(negedge clk);
    endtask
    task automatic cal(input logic exp);
        logic w;
        cal_done = 1'b1;
        @(negedge clk);
        cal_done = 1'b0;
        w = cal_coeff_write;
        repeat (2) begin
            @(negedge clk);
            w = w | cal_coeff_write;
        end
        check("cal write", 24'(w), 24'(exp));
    endtask
    task automatic print_verdict();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        check("ready", 24'(result_ready_n), 24'h1);
        check("oe idle", 24'(dout_oe_n), 24'h1);
        rd(8'h40, 8);
        check("status", 24'(rx[7:4]), 24'hC);
        rd(8'h41, 24);
        check("result", rx, 24'h000000);
        check("settled", 24'(filter_settled_flag), 24'h0);
    endtask
    task automatic t_load();
        strobe(24'h5A3C96);
        check("ready", 24'(result_ready_n), 24'h0);
        rd(8'h40, 8);
        check("status", 24'(rx[7:6]), 24'h0);
        rd(8'h41, 24);
        check("result", rx, 24'h5A3C96);
        check("ready", 24'(result_ready_n), 24'h1);
        word_length_select = 1'b0;
        strobe(24'hC3A501);
        rd(8'h41, 16);
        check("short result", rx, 24'h00C3A5);
        check("ready", 24'(result_ready_n), 24'h1);
        word_length_select = 1'b1;
    endtask
    task automatic t_write();
        logic [23:0] junk;
        u_host.xfer(24'h000001, 8, junk);
        u_host.xfer(24'hFFFFFF, 24, junk);
        rd(8'h41, 24);
        check("result", rx, 24'hC3A501);
    endtask
    task automatic t_overwrite();
        quick_settle_active = 1'b1;
        fir_settled = 1'b0;
        strobe(24'h111111);
        check("settled", 24'({filter_settled_flag, result_ready_n}), 24'h2);
        fir_settled = 1'b1;
        strobe(24'h222222);
        check("window", 24'({filter_settled_flag, result_ready_n}), 24'h3);
        repeat (HOLD - 2) @(negedge clk);
        check("window", 24'(result_ready_n), 24'h1);
        @(negedge clk);
        check("settled", 24'({filter_settled_flag, result_ready_n}), 24'h0);
        quick_settle_active = 1'b0;
        rd(8'h41, 24);
        check("result", rx, 24'h222222);
    endtask
    task automatic t_missing_reference_flag();
        ref_missing = 1'b1;
        repeat (3) @(negedge clk);
        check("missing_reference_flag", 24'(missing_reference_flag), 24'h1);
        strobe(24'h123456);
        rd(8'h41, 24);
        check("result", rx, 24'hFFFFFF);
        cal(1'b0);
        ref_missing = 1'b0;
        repeat (3) @(negedge clk);
        rd(8'h40, 8);
        check("status", 24'(rx[7:4]), 24'h8);
        cal(1'b1);
    endtask
    task automatic t_standby();
        standby_n = 1'b0;
        repeat (4) @(negedge clk);
        rd(8'h40, 8);
        check("status", 24'(rx[7:4]), 24'hA);
        standby_n = 1'b1;
        repeat (4) @(negedge clk);
        check("standby", 24'(standby_flag), 24'h0);
        operating_mode_field = adc_status_pkg::MODE_STANDBY;
        repeat (4) @(negedge clk);
        check("standby", 24'(standby_flag), 24'h1);
        operating_mode_field = 3'h1;
    endtask
    task automatic t_continuous();
        logic [23:0] junk;
        u_host.xfer(24'h000080, 8, junk);
        repeat (2) begin
            u_host.xfer(24'h000000, 8, rx); // din low keeps the stop code away
            check("cont status", 24'(rx[7:4]), 24'h8);
        end
        u_host.xfer(24'h000030, 8, junk);
        rd(8'h40, 8);
        check("status", 24'(rx[7:4]), 24'h8);
    endtask
    // ==========================================
    // main sequence
    initial begin
        n_fail = 0;
        checked = 0;
        rst = 1'b1;
        standby_n = 1'b1;
        ref_missing = 1'b0;
        result_strobe = 1'b0;
        result_value = 24'h000000;
        quick_settle_active = 1'b0;
        fir_settled = 1'b0;
        cal_done = 1'b0;
        word_length_select = 1'b1;
        operating_mode_field = 3'h0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_load();
        t_write();
        t_overwrite();
        t_missing_reference_flag();
        t_standby();
        t_continuous();
        print_verdict();
    end
    initial begin
        #300000;
        n_fail++;
        print_verdict();
    end
endmodule // adc_result_status_registers_bench
bind adc_result_status_registers result_status_sva #(.HOLD_CYCLES(HOLD_CYCLES)) u_sva (.*);
`default_nettype wire
